// ### hdl/adc_seq_pkg.sv
/*
 * constants, types and helpers shared by the converter sequencer files.
 * assumes a 200 MHz pclk and a byte-addressed 32-bit APB register bus.
 */
package adc_seq_pkg;
   // clock and conversion timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int CONV_TIME_NS = 13500;
   localparam int RES_BITS = 10;
   localparam int NUM_INPUTS = 16;
   localparam int NUM_RESULTS = 8;
   localparam int CONV_CYC = CONV_TIME_NS / CLK_PERIOD_NS;
   localparam int BIT_CYC = CONV_CYC / (RES_BITS + 1);
   localparam int SAMPLE_CYC = CONV_CYC - RES_BITS * BIT_CYC;
   localparam logic [11:0] BIT_CNT = 12'(BIT_CYC - 1);
   localparam logic [11:0] SAMPLE_CNT = 12'(SAMPLE_CYC - 1);

   // register byte offsets
   localparam logic [7:0] MODE_OFS = 8'h00;
   localparam logic [7:0] INT_STAT_OFS = 8'h04;
   localparam logic [7:0] INT_MASK_OFS = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0C;
   localparam logic [7:0] RESULT_BASE = 8'h20;
   localparam logic [7:0] RESULT_END = 8'h3C;

   // mode register fields
   localparam int MODE_EN_BIT = 0;
   localparam int MODE_START_BIT = 1;
   localparam int MODE_HW_BIT = 2;
   localparam int MODE_SCAN_BIT = 3;
   localparam int MODE_EDGE_BIT = 4;
   localparam int MODE_FIRST_LSB = 8;
   localparam int MODE_LAST_LSB = 12;

   // interrupt status fields and reset values
   localparam int INT_DONE_BIT = 0;
   localparam int INT_PASS_BIT = 1;
   localparam logic [1:0] INT_MASK_RST = 2'h0;
   localparam logic [3:0] CHAN_RST = 4'h0;
   localparam logic [9:0] SAR_MSB = 10'h200;
   localparam logic [9:0] SAR_LSB = 10'h001;

   typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} seq_state_e;

   // drop the trial bit when the input sits below the dac level
   function automatic logic [9:0] sar_resolve(input logic [9:0] code, input logic [9:0] mask,
                                              input logic keep);
      sar_resolve = keep ? code : (code & ~mask);
   endfunction : sar_resolve
endpackage : adc_seq_pkg

// ### hdl/approx_register.sv
/*
 * successive approximation register: one trial bit per step, msb first.
 * assumes the sequencer times the steps and supplies the comparator level.
 */
`timescale 1ns/100ps
module approx_register (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic load,
   input wire logic step,
   input wire logic comp_high,
   output logic [9:0] code,
   output logic [9:0] mask
);
   typedef struct packed {
      logic [9:0] code;
      logic [9:0] mask;
   } sar_s;

   sar_s r_r;
   sar_s r_nxt;

   always_comb begin
      r_nxt = r_r;
      if (load) begin
         r_nxt.code = adc_seq_pkg::SAR_MSB;
         r_nxt.mask = adc_seq_pkg::SAR_MSB;
      end else if (step) begin
         // resolve this bit, then try the next lower one
         r_nxt.code = adc_seq_pkg::sar_resolve(r_r.code, r_r.mask, comp_high) | (r_r.mask >> 1);
         r_nxt.mask = r_r.mask >> 1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_r <= '0;
      end else begin
         r_r <= r_nxt;
      end
   end

   assign code = r_r.code;
   assign mask = r_r.mask;
endmodule : approx_register

// ### hdl/result_store.sv
/*
 * eight 10-bit conversion result words, one write port, registered read.
 * assumes the read index is presented one cycle before the data is used.
 */
`timescale 1ns/100ps
module result_store (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic wr_en,
   input wire logic [2:0] wr_idx,
   input wire logic [9:0] wr_data,
   input wire logic [2:0] rd_idx,
   output logic [9:0] rd_data
);
   typedef struct packed {
      logic [7:0][9:0] mem;
      logic [9:0] rd;
   } store_s;

   store_s r_r;
   store_s r_nxt;

   always_comb begin
      r_nxt = r_r;
      // word holds until the next write to the same slot
      if (wr_en) begin
         r_nxt.mem[wr_idx] = wr_data;
      end
      r_nxt.rd = r_r.mem[rd_idx];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_r <= '0;
      end else begin
         r_r <= r_nxt;
      end
   end

   assign rd_data = r_r.rd;
endmodule : result_store

// ### hdl/adc_sequence_control.sv
/*
 * sequencer for a 16-input successive approximation converter with
 * eight result words, apb registers and one level interrupt.
 * assumes an external comparator reports analog input >= dac_code, and
 * that the trigger pin is already synchronous to pclk.
 */
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/100ps
// Contract
// - sixteen analog inputs selected through multiplexer
// - successive approximation, msb down to lsb
// - eight 10-bit result registers hold results
// - conversion timing counted in clock cycles
// - hardware start on external trigger edge
// - software start by mode register bit
// - scan mode steps through channel range
// - select mode repeats one chosen input
// - mode register controls start, mode, halt
// - interrupt on every result register transfer
module adc_sequence_control (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic external_trigger_input,
   input wire logic comparator_high,
   output logic [3:0] mux_select,
   output logic [9:0] dac_code,
   output logic sample_hold,
   output logic conversion_done_interrupt
);
   typedef struct packed {
      adc_seq_pkg::seq_state_e state;
      logic [11:0] cnt;
      logic [3:0] chan;
      logic [2:0] ridx;
      logic en;
      logic hw;
      logic scan;
      logic edge_fall;
      logic [3:0] first;
      logic [3:0] last;
      logic [1:0] int_stat;
      logic [1:0] int_mask;
      logic trig_prev;
   } ctl_s;

   ctl_s r_r;
   ctl_s r_nxt;

   logic [9:0] sar_code;
   logic [9:0] sar_mask;
   logic [9:0] rd_word;
   logic sar_load;
   logic sar_step;
   logic res_we;
   logic [9:0] res_data;
   logic wr_acc;
   logic rd_acc;
   logic sw_start;
   logic trig_edge;
   logic start;
   logic halt;
   logic last_bit;

   function automatic logic is_result(input logic [7:0] addr);
      is_result = (addr >= adc_seq_pkg::RESULT_BASE) && (addr <= adc_seq_pkg::RESULT_END)
                  && (addr[1:0] == 2'h0);
   endfunction : is_result

   function automatic logic is_mapped(input logic [7:0] addr);
      is_mapped = is_result(addr) || (addr == adc_seq_pkg::MODE_OFS)
                  || (addr == adc_seq_pkg::INT_STAT_OFS) || (addr == adc_seq_pkg::INT_MASK_OFS)
                  || (addr == adc_seq_pkg::STATUS_OFS);
   endfunction : is_mapped

   approx_register u_sar (
      .pclk(pclk),
      .presetn(presetn),
      .load(sar_load),
      .step(sar_step),
      .comp_high(comparator_high),
      .code(sar_code),
      .mask(sar_mask)
   );

   // read index comes straight from paddr so the word is ready by the access phase
   result_store u_store (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(res_we),
      .wr_idx(r_r.ridx),
      .wr_data(res_data),
      .rd_idx(paddr[4:2]),
      .rd_data(rd_word)
   );

   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;
   assign last_bit = (sar_mask == adc_seq_pkg::SAR_LSB);
   assign res_data = adc_seq_pkg::sar_resolve(sar_code, sar_mask, comparator_high);

   always_comb begin
      r_nxt = r_r;
      sar_load = 1'b0;
      sar_step = 1'b0;
      res_we = 1'b0;
      sw_start = 1'b0;
      r_nxt.trig_prev = external_trigger_input;

      // mode register: halt, start source, scan or select, channel range
      if (wr_acc && (paddr == adc_seq_pkg::MODE_OFS)) begin
         r_nxt.en = pwdata[adc_seq_pkg::MODE_EN_BIT];
         r_nxt.hw = pwdata[adc_seq_pkg::MODE_HW_BIT];
         r_nxt.scan = pwdata[adc_seq_pkg::MODE_SCAN_BIT];
         r_nxt.edge_fall = pwdata[adc_seq_pkg::MODE_EDGE_BIT];
         r_nxt.first = pwdata[adc_seq_pkg::MODE_FIRST_LSB +: 4];
         r_nxt.last = pwdata[adc_seq_pkg::MODE_LAST_LSB +: 4];
         sw_start = pwdata[adc_seq_pkg::MODE_START_BIT];
      end
      if (wr_acc && (paddr == adc_seq_pkg::INT_MASK_OFS)) begin
         r_nxt.int_mask = pwdata[1:0];
      end
      // read clears; sets below come later and so win in the same cycle
      if (rd_acc && (paddr == adc_seq_pkg::INT_STAT_OFS)) begin
         r_nxt.int_stat = 2'h0;
      end

      // pin edge only counts while hardware start is chosen
      trig_edge = r_nxt.hw && (r_r.edge_fall ? (r_r.trig_prev && !external_trigger_input)
                                             : (!r_r.trig_prev && external_trigger_input));
      // software start bit ignored in hardware start mode
      start = r_nxt.en && (r_nxt.hw ? trig_edge : sw_start);
      halt = !r_nxt.en;

      if (!halt && !start) begin
         case (r_r.state)
            adc_seq_pkg::ST_IDLE: begin
               r_nxt.cnt = 12'h000;
            end
            adc_seq_pkg::ST_SAMPLE: begin
               // sample window then ten bit periods, all cycle counted
               if (r_r.cnt == 12'h000) begin
                  r_nxt.state = adc_seq_pkg::ST_CONVERT;
                  r_nxt.cnt = adc_seq_pkg::BIT_CNT;
                  sar_load = 1'b1;
               end else begin
                  r_nxt.cnt = r_r.cnt - 12'h001;
               end
            end
            adc_seq_pkg::ST_CONVERT: begin
               if (r_r.cnt == 12'h000) begin
                  sar_step = 1'b1;
                  r_nxt.cnt = adc_seq_pkg::BIT_CNT;
                  if (last_bit) begin
                     res_we = 1'b1;
                     r_nxt.int_stat[adc_seq_pkg::INT_DONE_BIT] = 1'b1;
                     r_nxt.ridx = r_r.ridx + 3'h1;
                     r_nxt.state = adc_seq_pkg::ST_SAMPLE;
                     r_nxt.cnt = adc_seq_pkg::SAMPLE_CNT;
                     if (r_r.scan) begin
                        // scan walks first..last then starts over
                        if (r_r.chan == r_r.last) begin
                           r_nxt.chan = r_r.first;
                           r_nxt.int_stat[adc_seq_pkg::INT_PASS_BIT] = 1'b1;
                        end else begin
                           r_nxt.chan = r_r.chan + 4'h1;
                        end
                     end else begin
                        r_nxt.chan = r_r.first;
                     end
                  end
               end else begin
                  r_nxt.cnt = r_r.cnt - 12'h001;
               end
            end
            default: begin
               r_nxt.state = adc_seq_pkg::ST_IDLE;
            end
         endcase
      end

      // a fresh start restarts the sequence from the first channel
      if (start) begin
         r_nxt.state = adc_seq_pkg::ST_SAMPLE;
         r_nxt.cnt = adc_seq_pkg::SAMPLE_CNT;
         r_nxt.chan = r_nxt.first;
         r_nxt.ridx = 3'h0;
      end
      // halt drops any conversion; no write, no interrupt reaches this path
      if (halt) begin
         r_nxt.state = adc_seq_pkg::ST_IDLE;
         r_nxt.cnt = 12'h000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_r <= '{state: adc_seq_pkg::ST_IDLE, cnt: 12'h000, chan: adc_seq_pkg::CHAN_RST,
                  ridx: 3'h0, en: 1'b0, hw: 1'b0, scan: 1'b0, edge_fall: 1'b0,
                  first: adc_seq_pkg::CHAN_RST, last: adc_seq_pkg::CHAN_RST, int_stat: 2'h0,
                  int_mask: adc_seq_pkg::INT_MASK_RST, trig_prev: 1'b0};
      end else begin
         r_r <= r_nxt;
      end
   end

   // register read mux; unmapped or misaligned reads give zero and an error
   always_comb begin
      prdata = 32'h0000_0000;
      if (is_result(paddr)) begin
         prdata = {22'h00_0000, rd_word};
      end else begin
         case (paddr)
            adc_seq_pkg::MODE_OFS: begin
               prdata = {16'h0000, r_r.last, r_r.first, 3'h0, r_r.edge_fall, r_r.scan,
                         r_r.hw, 1'b0, r_r.en};
            end
            adc_seq_pkg::INT_STAT_OFS: begin
               prdata = {30'h0000_0000, r_r.int_stat};
            end
            adc_seq_pkg::INT_MASK_OFS: begin
               prdata = {30'h0000_0000, r_r.int_mask};
            end
            adc_seq_pkg::STATUS_OFS: begin
               prdata = {21'h00_0000, r_r.ridx, r_r.chan, 3'h0,
                         (r_r.state != adc_seq_pkg::ST_IDLE)};
            end
            default: begin
               prdata = 32'h0000_0000;
            end
         endcase
      end
   end

   // zero wait states: the result word was fetched during the setup cycle
   assign pready = 1'b1;
   assign pslverr = psel && penable && !is_mapped(paddr);

   assign mux_select = r_r.chan;
   assign dac_code = sar_code;
   assign sample_hold = (r_r.state == adc_seq_pkg::ST_SAMPLE);
   assign conversion_done_interrupt = |(r_r.int_stat & r_r.int_mask);
endmodule : adc_sequence_control

// ### verification/adc_seq_props.sv
/*
 * port checker for the converter sequencer: bus answer, sample timing,
 * trial order, channel stepping and interrupt behaviour.
 * assumes one pclk domain with presetn; bound to the top module below.
 */
`timescale 1ns/100ps
module adc_seq_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [3:0] mux_select,
   input wire logic [9:0] dac_code,
   input wire logic sample_hold,
   input wire logic conversion_done_interrupt
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic acc;
   logic wr_seen;
   logic [8:0] samp_cnt_r;
   assign acc = psel && penable;
   assign wr_seen = psel && pwrite;
   // counts the length of the sample phase that just ended
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) samp_cnt_r <= 9'h000;
      else samp_cnt_r <= sample_hold ? samp_cnt_r + 9'h001 : 9'h000;
   end
   a_ready_always: assert property (pready) else $error("pready low");
   a_err_unmapped: assert property (acc && paddr == 8'h10 |-> pslverr) else $error("no error");
   a_err_mapped: assert property (acc && paddr == 8'h00 |-> !pslverr) else $error("false error");
   // writes are excluded: a halt may end the phase early
   a_sample_length: assert property ($fell(sample_hold) && !$past(wr_seen) |-> samp_cnt_r == 9'h0FA)
      else $error("sample length");
   a_msb_first: assert property ($fell(sample_hold) && !$past(wr_seen) |-> dac_code == 10'h200)
      else $error("first trial not msb");
   a_irq_after_conv: assert property ($rose(conversion_done_interrupt) && !$past(wr_seen)
      |-> !$past(sample_hold)) else $error("irq without result");
   a_stat_read_clears: assert property (acc && !pwrite && paddr == 8'h04
      |=> !conversion_done_interrupt || $rose(sample_hold)) else $error("irq not cleared");
   a_mux_steps: assert property ($changed(mux_select) && !$past(wr_seen) |-> $rose(sample_hold))
      else $error("channel change off result");
   a_sample_stable: assert property (sample_hold && $past(sample_hold) |-> $stable(mux_select))
      else $error("channel moved in sample");
endmodule : adc_seq_props
bind adc_sequence_control adc_seq_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pready, .pslverr, .mux_select, .dac_code, .sample_hold, .conversion_done_interrupt);

// ### verification/analog_source.sv
/*
 * sixteen analog levels behind the input multiplexer plus an ideal comparator.
 * assumes the bench sets level[] directly; levels are 10-bit codes.
 */
`timescale 1ns/100ps
module analog_source (
   input wire logic pclk,
   input wire logic [3:0] mux_select,
   input wire logic sample_hold,
   input wire logic [9:0] dac_code,
   output logic comparator_high
);
   logic [9:0] level [16];
   logic [9:0] held_r = 10'h000;
   // tracks while sampling, so a late level change lands only in a fresh sample
   always @(posedge pclk) begin
      if (sample_hold) held_r <= level[mux_select];
   end
   assign comparator_high = held_r >= dac_code;
endmodule : analog_source

// ### verification/test_adc_sequence_control.sv
/*
 * self-checking bench: apb reads note expectations, a monitor compares them.
 * assumes analog_source as the far side and the bound checker.
 */
`timescale 1ns/100ps
module test_adc_sequence_control;
   typedef struct packed {logic [32:0] m; logic [32:0] v;} note_s;
   localparam logic [32:0] ALL = 33'h1FFFFFFFF;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic external_trigger_input = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, comparator_high, sample_hold, conversion_done_interrupt;
   logic [3:0] mux_select;
   logic [9:0] dac_code;
   note_s notes[$];
   note_s n;
   int fail_count = 0;
   int checks = 0;
   int cyc = 0;
   always #2.5 pclk = ~pclk;
   adc_sequence_control u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .external_trigger_input, .comparator_high, .mux_select, .dac_code,
      .sample_hold, .conversion_done_interrupt);
   analog_source u_src (.pclk, .mux_select, .sample_hold, .dac_code, .comparator_high);
   task automatic cmp(input logic [32:0] seen, input logic [32:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : cmp
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_sim
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [32:0] m, input logic [32:0] v);
      notes.push_back('{m, v});
      apb(1'b0, a, 32'h0);
   endtask : rd
   // polled on the falling edge so register updates have landed
   task automatic wait_irq();
      int k;
      k = 0;
      while (conversion_done_interrupt !== 1'b1 && k < 4000) begin
         @(negedge pclk);
         k++;
      end
      cmp({32'h0, conversion_done_interrupt}, 33'h1);
   endtask : wait_irq
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0) begin
         n = notes.pop_front();
         cmp({pslverr, prdata} & n.m, n.v);
      end
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         fail_count++;
         $display("mismatch at %0t: run too long", $time);
         end_sim();
      end
   end
   initial begin
      int ch;
      void'($urandom(32'h5923b538));
      for (int i = 0; i < 16; i++) u_src.level[i] = 10'($urandom());
      u_src.level[0] = 10'h000;
      u_src.level[15] = 10'h3FF;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 4; i++) rd(8'(4 * i), ALL, 33'h0);
      rd(8'h10, ALL, {1'b1, 32'h0});
      rd(8'h22, ALL, {1'b1, 32'h0});
      apb(1'b1, 8'h20, 32'h3FF);
      rd(8'h20, ALL, 33'h0);
      apb(1'b1, 8'h08, 32'h1);
      rd(8'h08, ALL, 33'h1);
      apb(1'b1, 8'h00, 32'h5503);
      wait_irq();
      rd(8'h04, 33'h1, 33'h1);
      rd(8'h20, ALL, {23'h0, u_src.level[5]});
      u_src.level[5] = ~u_src.level[5];
      wait_irq();
      rd(8'h04, 33'h1, 33'h1);
      rd(8'h24, ALL, {23'h0, u_src.level[5]});
      apb(1'b1, 8'h00, 32'h0);
      repeat (3000) @(posedge pclk);
      rd(8'h04, ALL, 33'h0);
      rd(8'h0C, 33'h1, 33'h0);
      rd(8'h28, ALL, 33'h0);
      // start bit with hardware start selected must not begin a conversion
      apb(1'b1, 8'h00, 32'h9907);
      repeat (300) @(posedge pclk);
      rd(8'h0C, 33'h1, 33'h0);
      external_trigger_input <= 1'b1;
      wait_irq();
      rd(8'h04, 33'h1, 33'h1);
      rd(8'h20, ALL, {23'h0, u_src.level[9]});
      apb(1'b1, 8'h00, 32'h0);
      // falling-edge start; pin still high, so only its drop may start
      apb(1'b1, 8'h00, 32'h3315);
      external_trigger_input <= 1'b0;
      wait_irq();
      rd(8'h04, 33'h1, 33'h1);
      rd(8'h20, ALL, {23'h0, u_src.level[3]});
      // halt first: a restart inside a sample phase would stretch it
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b1, 8'h00, 32'h1E0B);
      for (int i = 0; i < 9; i++) begin
         ch = (14 + i % 4) % 16;
         wait_irq();
         rd(8'h04, 33'h3, {31'h0, i % 4 == 3, 1'b1});
         rd(8'(8'h20 + 4 * (i % 8)), ALL, {23'h0, u_src.level[ch]});
         if (i == 7) u_src.level[14] = ~u_src.level[14];
      end
      rd(8'h0C, 33'h700, 33'h100);
      apb(1'b1, 8'h08, 32'h0);
      repeat (2800) @(negedge pclk);
      cmp({32'h0, conversion_done_interrupt}, 33'h0);
      rd(8'h04, 33'h1, 33'h1);
      apb(1'b1, 8'h00, 32'h0);
      end_sim();
   end
endmodule : test_adc_sequence_control
